// file: src/ext_mem_irq_nand_ecc_page_ctrl_regs.sv
// control and status register group of the external memory interface
// assumes events and ecc results come from the surrounding controller
`include "flash_regs_cfg.svh"
`default_nettype none

module ext_mem_irq_nand_ecc_page_ctrl_regs #(
    parameter int CS_COUNT = 4                // chip selects served
) (
    input  wire logic        ref_clk,         // 200 MHz clock
    input  wire logic        sys_rst,         // synchronous reset, high
    input  wire logic [7:0]  reg_addr,        // register word address
    input  wire logic [15:0] reg_wdata,       // write data
    input  wire logic        reg_wr,          // write strobe
    input  wire logic        reg_rd,          // read strobe
    output logic      [15:0] reg_rdata,       // read data, cycle after strobe
    input  wire logic [3:0]  wait_input_pins, // raw wait pins
    input  wire logic        line_trap_evt,   // illegal access pulse
    input  wire logic        async_tmo_evt,   // async timeout pulse
    input  wire logic        locate_rd,       // error address/value read
    input  wire logic        quad_code_rd,    // quad code register read
    input  wire logic [3:0]  parity_code_rd,  // per chip select code read
    input  wire logic        locate_uncorr,   // engine found five or more
    input  wire logic        locate_bit89,    // errors on bit 8 or 9
    input  wire logic [2:0]  locate_errs,     // errors found, 0..4
    output logic             irq_line,        // level interrupt
    output logic             event_pulse,     // masked event pulse
    output logic [3:0]       parity_run,      // parity calc active per cs
    output logic [3:0]       quad_run_cs,     // quad calc steered cs
    output logic [3:0]       flash_mode,      // nand attached per cs
    output logic [31:0]      page_cfg         // packed page settings
);

    // ------------------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------------------
    if (CS_COUNT != 4)
    begin : g_bad
        $error("only four chip selects are served");
    end

    localparam int STEPS = `STEP_CYCLES;

    typedef struct packed {
        logic [5:0]                 raw;
        logic [5:0]                 masked;
        logic [5:0]                 enable;
        logic [5:0]                 irq_stat;
        logic [5:0]                 irq_mask;
        logic                       locate_start;
        logic                       quad_start;
        logic [3:0]                 parity_start;
        logic [1:0]                 quad_sel;
        logic [3:0]                 flash_mode;
        flash_regs_pkg::page_cfg_t [3:0] page;
        logic [3:0]                 wait_prev;
        flash_regs_pkg::loc_phase_t phase;
        logic [3:0]                 corr_state;
        logic [1:0]                 err_num;
        logic [7:0]                 step_cnt;
        logic [15:0]                rdata;
        logic                       irq;
        logic                       pulse;
        logic [3:0]                 par_run;
        logic [3:0]                 quad_cs;
    } state_t;

    state_t cur_ff;
    state_t nxt_cur;
    flash_regs_pkg::reg_req_t req;
    logic [5:0] evt;
    logic       step_done;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
    assign step_done = (cur_ff.step_cnt == 8'(STEPS - 1));

    // ------------------------------------------------------------------------
    // event sources
    // ------------------------------------------------------------------------
    // wait rise edges, line trap, timeout gathered in register layout
    assign evt = {wait_input_pins & ~cur_ff.wait_prev, line_trap_evt, async_tmo_evt};

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb
    begin
        nxt_cur = cur_ff;
        nxt_cur.wait_prev = wait_input_pins;
        nxt_cur.rdata = 16'h0000;

        nxt_cur.raw = cur_ff.raw | evt;
        nxt_cur.masked = cur_ff.masked | (evt & cur_ff.enable);
        nxt_cur.pulse = |(evt & cur_ff.enable);
        nxt_cur.irq_stat = cur_ff.irq_stat | evt;

        if (req.wr && req.addr == `OFS_IRQ_ENABLE_SET)
            nxt_cur.enable = cur_ff.enable | req.wdata[5:0];
        if (req.wr && req.addr == `OFS_IRQ_ENABLE_CLEAR)
            nxt_cur.enable = cur_ff.enable & ~req.wdata[5:0];

        // write-one clears; a same-cycle event wins
        if (req.wr && (req.addr == `OFS_RAW_EVENT || req.addr == `OFS_MASKED_EVENT))
        begin
            nxt_cur.raw = (cur_ff.raw & ~req.wdata[5:0]) | evt;
            nxt_cur.masked = (cur_ff.masked & ~req.wdata[5:0]) | (evt & cur_ff.enable);
        end
        if (req.wr && req.addr == `OFS_IRQ_STATUS)
            nxt_cur.irq_stat = (cur_ff.irq_stat & ~req.wdata[5:0]) | evt;
        if (req.wr && req.addr == `OFS_IRQ_MASK)
            nxt_cur.irq_mask = req.wdata[5:0];

        if (req.wr && req.addr == `OFS_FLASH_ECC_CTRL)
        begin
            nxt_cur.locate_start = cur_ff.locate_start | req.wdata[`POS_LOCATE_START];
            nxt_cur.quad_start = cur_ff.quad_start | req.wdata[`POS_QUAD_START];
            nxt_cur.parity_start = cur_ff.parity_start | req.wdata[`POS_PARITY_START +: 4];
            nxt_cur.quad_sel = req.wdata[`POS_QUAD_SEL +: 2];
            nxt_cur.flash_mode = req.wdata[`POS_FLASH_MODE +: 4];
        end
        if (quad_code_rd)
            nxt_cur.quad_start = 1'b0;
        nxt_cur.parity_start = nxt_cur.parity_start & ~parity_code_rd;

        if (req.wr && req.addr == `OFS_PAGE_MODE_LOW)
        begin
            nxt_cur.page[0] = req.wdata[7:0];
            nxt_cur.page[1] = req.wdata[15:8];
        end
        if (req.wr && req.addr == `OFS_PAGE_MODE_HIGH)
        begin
            nxt_cur.page[2] = req.wdata[7:0];
            nxt_cur.page[3] = req.wdata[15:8];
        end

        nxt_cur.step_cnt = step_done ? 8'h00 : cur_ff.step_cnt + 8'h01;
        unique case (cur_ff.phase)
            flash_regs_pkg::LOC_IDLE:
            begin
                nxt_cur.step_cnt = 8'h00;
                if (req.wr && req.addr == `OFS_FLASH_ECC_CTRL && req.wdata[`POS_LOCATE_START])
                begin
                    nxt_cur.phase = flash_regs_pkg::LOC_COUNT;
                    nxt_cur.corr_state = `CST_COUNTING;
                end
            end
            flash_regs_pkg::LOC_COUNT:
                if (step_done)
                begin
                    nxt_cur.phase = flash_regs_pkg::LOC_PREP;
                    nxt_cur.corr_state = `CST_PREP_A;
                end
            flash_regs_pkg::LOC_PREP:
                if (step_done)
                begin
                    if (cur_ff.corr_state == `CST_PREP_A)
                        nxt_cur.corr_state = `CST_PREP_B;
                    else
                    begin
                        nxt_cur.phase = flash_regs_pkg::LOC_SEARCH;
                        nxt_cur.corr_state = `CST_SEARCHING;
                    end
                end
            flash_regs_pkg::LOC_SEARCH:
                if (step_done)
                begin
                    nxt_cur.phase = flash_regs_pkg::LOC_VALUE;
                    nxt_cur.corr_state = `CST_VALUE_FIRST;
                end
            flash_regs_pkg::LOC_VALUE:
                if (step_done)
                begin
                    if (cur_ff.corr_state != `CST_VALUE_LAST)
                        nxt_cur.corr_state = cur_ff.corr_state + 4'h1;
                    else
                    begin
                        nxt_cur.phase = flash_regs_pkg::LOC_IDLE;
                        if (locate_uncorr)
                            nxt_cur.corr_state = `CST_UNCORRECTABLE;
                        else if (locate_errs == 3'd0)
                            nxt_cur.corr_state = `CST_NO_ERROR;
                        else if (locate_bit89)
                            nxt_cur.corr_state = `CST_DONE_BIT89;
                        else
                            nxt_cur.corr_state = `CST_DONE;
                        if (locate_errs != 3'd0 && !locate_uncorr)
                            nxt_cur.err_num = 2'(locate_errs - 3'd1);
                    end
                end
            default:
                nxt_cur.phase = flash_regs_pkg::LOC_IDLE;
        endcase
        if (locate_rd)
            nxt_cur.locate_start = 1'b0;

        if (req.rd)
        begin
            unique case (req.addr)
                `OFS_RAW_EVENT:        nxt_cur.rdata = {10'h000, cur_ff.raw};
                `OFS_MASKED_EVENT:     nxt_cur.rdata = {10'h000, cur_ff.masked};
                `OFS_IRQ_ENABLE_SET:   nxt_cur.rdata = {10'h000, cur_ff.enable};
                `OFS_IRQ_ENABLE_CLEAR: nxt_cur.rdata = {10'h000, cur_ff.enable};
                `OFS_FLASH_ECC_CTRL:   nxt_cur.rdata = {2'b00, cur_ff.locate_start,
                                           cur_ff.quad_start, cur_ff.parity_start,
                                           2'b00, cur_ff.quad_sel, cur_ff.flash_mode};
                `OFS_FLASH_STATUS_1:   nxt_cur.rdata = {4'h0, cur_ff.corr_state,
                                           4'h0, wait_input_pins};
                `OFS_FLASH_STATUS_2:   nxt_cur.rdata = {14'h0000, cur_ff.err_num};
                `OFS_PAGE_MODE_LOW:    nxt_cur.rdata = {cur_ff.page[1], cur_ff.page[0]};
                `OFS_PAGE_MODE_HIGH:   nxt_cur.rdata = {cur_ff.page[3], cur_ff.page[2]};
                `OFS_IRQ_STATUS:       nxt_cur.rdata = {10'h000, cur_ff.irq_stat};
                `OFS_IRQ_MASK:         nxt_cur.rdata = {10'h000, cur_ff.irq_mask};
                default:               nxt_cur.rdata = 16'h0000;
            endcase
        end

        nxt_cur.irq = |(nxt_cur.irq_stat & nxt_cur.irq_mask);
        // parity only where nand is attached
        nxt_cur.par_run = nxt_cur.parity_start & nxt_cur.flash_mode;
        nxt_cur.quad_cs = nxt_cur.quad_start ? 4'(4'h1 << nxt_cur.quad_sel) : 4'h0;
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            cur_ff <= '0;
            cur_ff.flash_mode <= `RST_FLASH_MODE;
            cur_ff.page[0] <= {`RST_PAGE_DELAY, 1'b1, 1'b0};
            cur_ff.page[1] <= {`RST_PAGE_DELAY, 1'b0, 1'b0};
            cur_ff.page[2] <= {`RST_PAGE_DELAY, 1'b0, 1'b0};
            cur_ff.page[3] <= {`RST_PAGE_DELAY, 1'b0, 1'b0};
        end
        else
            cur_ff <= nxt_cur;
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    assign reg_rdata = cur_ff.rdata;
    assign irq_line = cur_ff.irq;
    assign event_pulse = cur_ff.pulse;
    assign parity_run = cur_ff.par_run;
    assign quad_run_cs = cur_ff.quad_cs;
    assign flash_mode = cur_ff.flash_mode;
    assign page_cfg = cur_ff.page;

endmodule

`default_nettype wire

// file: src/flash_regs_cfg.svh
// offsets, field positions, reset values and timing counts of the register group
// assumes a 16-bit register port with word offsets of our own choosing
`ifndef FLASH_REGS_CFG_SVH
`define FLASH_REGS_CFG_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define OFS_RAW_EVENT        8'h00
`define OFS_MASKED_EVENT     8'h01
`define OFS_IRQ_ENABLE_SET   8'h02
`define OFS_IRQ_ENABLE_CLEAR 8'h03
`define OFS_FLASH_ECC_CTRL   8'h04
`define OFS_FLASH_STATUS_1   8'h05
`define OFS_FLASH_STATUS_2   8'h06
`define OFS_PAGE_MODE_LOW    8'h07
`define OFS_PAGE_MODE_HIGH   8'h08
`define OFS_IRQ_STATUS       8'h09
`define OFS_IRQ_MASK         8'h0A

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define POS_ASYNC_TIMEOUT    0
`define POS_LINE_TRAP        1
`define POS_WAIT_RISE        2
`define POS_FLASH_MODE       0
`define POS_QUAD_SEL         4
`define POS_PARITY_START     8
`define POS_QUAD_START       12
`define POS_LOCATE_START     13
`define POS_CORR_STATE       8
`define POS_PAGE_EN          0
`define POS_PAGE_SIZE        1
`define POS_PAGE_DELAY       2

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define RST_FLASH_MODE       4'h1
`define RST_PAGE_DELAY       6'h3F
`define RST_PAGE_SIZE        4'h1

// ----------------------------------------------------------------------------
// correction states and timing
// ----------------------------------------------------------------------------
`define CST_NO_ERROR         4'h0
`define CST_UNCORRECTABLE    4'h1
`define CST_DONE_BIT89       4'h2
`define CST_DONE             4'h3
`define CST_COUNTING         4'h5
`define CST_PREP_A           4'h6
`define CST_PREP_B           4'h7
`define CST_SEARCHING        4'h8
`define CST_VALUE_FIRST      4'hC
`define CST_VALUE_LAST       4'hF
`define STEP_NS              20
`define CLK_PERIOD_NS        5
`define STEP_CYCLES          ((`STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: src/flash_regs_pkg.sv
// types shared by the register group
// assumes the config header supplies the numbers
`default_nettype none

package flash_regs_pkg;

    // ------------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    typedef struct packed {
        logic [5:0] delay;
        logic       size8;
        logic       enable;
    } page_cfg_t;

    // locate engine phases
    typedef enum logic [2:0] {
        LOC_IDLE   = 3'b000,
        LOC_COUNT  = 3'b001,
        LOC_PREP   = 3'b010,
        LOC_SEARCH = 3'b011,
        LOC_VALUE  = 3'b100
    } loc_phase_t;

endpackage

`default_nettype wire

// file: tb/flash_regs_properties.sv
// port assertions for the register group
// assumes a bind from the bench top, one clock, sync reset
`include "flash_regs_cfg.svh"
`default_nettype none

module flash_regs_properties (
    input wire logic        ref_clk,        // clock
    input wire logic        sys_rst,        // sync reset
    input wire logic [7:0]  reg_addr,       // address
    input wire logic [15:0] reg_wdata,      // write data
    input wire logic        reg_wr,         // write strobe
    input wire logic        reg_rd,         // read strobe
    input wire logic [15:0] reg_rdata,      // read data
    input wire logic        quad_code_rd,   // quad code read
    input wire logic [3:0]  parity_code_rd, // parity code reads
    input wire logic [3:0]  parity_run,     // parity active
    input wire logic [3:0]  quad_run_cs,    // quad steering
    input wire logic [3:0]  flash_mode,     // nand attached
    input wire logic [31:0] page_cfg        // page settings
);
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data not zero outside read");
    AST_RST_VALUES: assert property ($fell(sys_rst) |-> page_cfg == 32'hFCFCFCFE && flash_mode == 4'h1)
        else $error("reset values wrong");
    AST_QUAD_START: assert property (reg_wr && reg_addr == `OFS_FLASH_ECC_CTRL && reg_wdata[12]
        |=> quad_run_cs == 4'(4'h1 << $past(reg_wdata[5:4])))
        else $error("quad steering wrong");
    AST_QUAD_CLEAR: assert property (quad_code_rd && !reg_wr |=> quad_run_cs == 4'h0)
        else $error("quad start not cleared");
    AST_PARITY_START: assert property (reg_wr && reg_addr == `OFS_FLASH_ECC_CTRL
        |=> (parity_run & $past(reg_wdata[11:8])) == ($past(reg_wdata[11:8]) & $past(reg_wdata[3:0])))
        else $error("parity start wrong");
    AST_PARITY_CLEAR: assert property ((parity_code_rd != 4'h0) && !reg_wr
        |=> (parity_run & $past(parity_code_rd)) == 4'h0)
        else $error("parity start not cleared");
    AST_PARITY_MODE: assert property ((parity_run & ~flash_mode) == 4'h0)
        else $error("parity on non flash select");
    AST_FLASH_WRITE: assert property (reg_wr && reg_addr == `OFS_FLASH_ECC_CTRL
        |=> flash_mode == $past(reg_wdata[3:0]))
        else $error("flash mode not written");
    AST_PAGE_LOW: assert property (reg_wr && reg_addr == `OFS_PAGE_MODE_LOW
        |=> page_cfg[15:0] == $past(reg_wdata))
        else $error("page low not written");
    AST_PAGE_HIGH: assert property (reg_wr && reg_addr == `OFS_PAGE_MODE_HIGH
        |=> page_cfg[31:16] == $past(reg_wdata))
        else $error("page high not written");
    AST_PAGE_HOLD: assert property (!reg_wr |=> $stable(page_cfg))
        else $error("page settings moved");
endmodule

`default_nettype wire

// file: tb/flash_wait_model.sv
// flash side model driving the wait pins
// assumes the bench commands busy per chip select
`default_nettype none

module flash_wait_model (
    input  wire logic       ref_clk,         // clock
    input  wire logic       sys_rst,         // sync reset
    input  wire logic [3:0] busy_req,        // busy command per cs
    output logic      [3:0] wait_input_pins  // wait pin levels
);
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            wait_input_pins <= 4'h0;
        else
            wait_input_pins <= busy_req;
    end
endmodule

`default_nettype wire

// file: tb/tb_ext_mem_irq_nand_ecc_page_ctrl_regs.sv
// self-checking bench for the register group
// assumes the flash model as partner and the config header offsets
`include "flash_regs_cfg.svh"
`default_nettype none

module tb_ext_mem_irq_nand_ecc_page_ctrl_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [3:0]  busy_req = 4'h0;
    logic        line_trap_evt = 1'b0;
    logic        async_tmo_evt = 1'b0;
    logic        locate_rd = 1'b0;
    logic        quad_code_rd = 1'b0;
    logic [3:0]  parity_code_rd = 4'h0;
    logic        locate_uncorr = 1'b0;
    logic        locate_bit89 = 1'b0;
    logic [2:0]  locate_errs = 3'h0;
    logic [15:0] reg_rdata;
    logic [3:0]  wait_input_pins;
    logic        irq_line;
    logic        event_pulse;
    logic [3:0]  parity_run;
    logic [3:0]  quad_run_cs;
    logic [3:0]  flash_mode;
    logic [31:0] page_cfg;
    int          mismatches = 0;
    int          num_checks = 0;
    int          pulses = 0;
    integer      seed = 71;
    localparam logic [15:0] RST_TAB [12] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0001, 16'h0,
        16'h0, 16'hFCFE, 16'hFCFC, 16'h0, 16'h0, 16'h0};
    localparam logic [3:0] SEQ [8] = '{4'h5, 4'h6, 4'h7, 4'h8, 4'hC, 4'hD, 4'hE, 4'hF};
    localparam logic [7:0] LOC_CASE [3] = '{8'h63, 8'h34, 8'h4A};

    // ------------------------------------------------------------------
    // clock, design, partner, event monitor
    // ------------------------------------------------------------------
    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (event_pulse === 1'b1) pulses++;

    ext_mem_irq_nand_ecc_page_ctrl_regs i_dut (.ref_clk, .sys_rst, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .wait_input_pins, .line_trap_evt, .async_tmo_evt,
        .locate_rd, .quad_code_rd, .parity_code_rd, .locate_uncorr, .locate_bit89,
        .locate_errs, .irq_line, .event_pulse, .parity_run, .quad_run_cs, .flash_mode,
        .page_cfg);
    flash_wait_model i_flash (.ref_clk, .sys_rst, .busy_req, .wait_input_pins);

    // ------------------------------------------------------------------
    // bus tasks and compare
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] d;
        rd(a, d);
        chk({16'h0, d}, {16'h0, e});
    endtask
    // side pulses: locate read, line trap, timeout, quad read, parity reads
    task automatic pulse(input logic [7:0] p);
        @(posedge ref_clk);
        {locate_rd, line_trap_evt, async_tmo_evt, quad_code_rd, parity_code_rd} <= p;
        @(posedge ref_clk);
        {locate_rd, line_trap_evt, async_tmo_evt, quad_code_rd, parity_code_rd} <= 8'h00;
    endtask
    task automatic summarize();
        if (mismatches == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        logic [15:0] en, ctl, d;
        logic [15:0] pg [2];
        logic [31:0] r;
        logic [7:0]  a;
        logic [3:0]  seen [$];
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        chk(page_cfg, 32'hFCFCFCFE);
        foreach (RST_TAB[i]) rchk(8'(i), RST_TAB[i]);
        wr(8'h0B, 16'hFFFF);
        rchk(8'h0B, 16'h0000);
        // enable set and clear in random order
        en = 16'h0000;
        repeat (24)
        begin
            r = $random(seed);
            wr(r[16] ? 8'h02 : 8'h03, r[15:0]);
            en = r[16] ? (en | (r[15:0] & 16'h003F)) : (en & ~r[15:0]);
            rchk(8'h02, en);
            rchk(8'h03, en);
        end
        // page settings, never a zero delay
        pg = '{16'hFCFE, 16'hFCFC};
        repeat (8)
        begin
            r = $random(seed);
            a = r[16] ? 8'h08 : 8'h07;
            d = r[15:0] | 16'h0404;
            wr(a, d);
            pg[a[3]] = d;
            rchk(a, d);
            chk(page_cfg, {pg[1], pg[0]});
        end
        // control starts, steering and code reads
        ctl = 16'h0001;
        repeat (24)
        begin
            r = $random(seed);
            wr(8'h04, r[15:0] & 16'hDFFF);
            ctl = (ctl & 16'h1F00) | (r[15:0] & 16'h1F3F);
            rchk(8'h04, ctl);
            chk(32'(parity_run), 32'(ctl[11:8] & ctl[3:0]));
            chk(32'(quad_run_cs), ctl[12] ? 32'(4'h1 << ctl[5:4]) : 32'h0);
            chk(32'(flash_mode), 32'(ctl[3:0]));
            pulse({3'b000, r[21:17]});
            ctl[12:8] = ctl[12:8] & ~r[21:17];
            rchk(8'h04, ctl);
        end
        // drop leftover quad and parity starts before the locate runs
        pulse(8'h1F);
        rchk(8'h04, ctl & 16'h003F);
        // events enabled, then line trap disabled
        wr(8'h00, 16'h003F);
        wr(8'h02, 16'h003F);
        wr(8'h0A, 16'h003F);
        busy_req <= 4'h4;
        pulse(8'h60);
        rchk(8'h00, 16'h0013);
        rchk(8'h01, 16'h0013);
        rchk(8'h05, 16'h0004);
        chk(32'(irq_line), 32'h1);
        chk(32'(pulses != 0), 32'h1);
        wr(8'h03, 16'h0002);
        wr(8'h01, 16'h003F);
        pulses = 0;
        pulse(8'h40);
        rchk(8'h00, 16'h0002);
        rchk(8'h01, 16'h0000);
        chk(32'(pulses), 32'h0);
        wr(8'h0A, 16'h0000);
        wr(8'h09, 16'h003F);
        @(posedge ref_clk);
        #1 chk(32'(irq_line), 32'h0);
        // locate engine outcomes
        foreach (LOC_CASE[k])
        begin
            {locate_uncorr, locate_bit89, locate_errs} <= LOC_CASE[k][4:0];
            wr(8'h04, 16'h2001);
            seen = {};
            repeat (40)
            begin
                rd(8'h05, d);
                if ((seen.size() != 0 || d[11:8] == 4'h5) && (seen.size() == 0 || seen[$] != d[11:8]))
                    seen.push_back(d[11:8]);
            end
            foreach (SEQ[i]) chk(32'(seen[i]), 32'(SEQ[i]));
            chk(32'(seen[8]), 32'(LOC_CASE[k][6:5]));
            if (!LOC_CASE[k][4]) rchk(8'h06, 16'(LOC_CASE[k][2:0] - 3'h1));
            rchk(8'h04, 16'h2001);
            pulse(8'h80);
            rchk(8'h04, 16'h0001);
        end
        summarize();
    end

    // watchdog
    initial
    begin
        #50000;
        mismatches++;
        summarize();
    end
endmodule

bind ext_mem_irq_nand_ecc_page_ctrl_regs flash_regs_properties i_props (.ref_clk, .sys_rst,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .quad_code_rd, .parity_code_rd,
    .parity_run, .quad_run_cs, .flash_mode, .page_cfg);

`default_nettype wire
